/* rtl/ipa_pkg.sv */
// constants shared by both ends of the interrupt acknowledge link
`default_nettype none
package ipa_pkg;
  // =====================================================
  // register map (byte addresses)
  localparam logic [7:0] IPA_ADDR_CTRL = 8'h00;
  localparam logic [7:0] IPA_ADDR_PIT = 8'h04;
  localparam logic [7:0] IPA_ADDR_VEC = 8'h08;
  localparam logic [7:0] IPA_ADDR_STAT = 8'h0C;
  // =====================================================
  // control register fields
  localparam int IPA_MASK_LSB = 5;
  localparam int IPA_PLVL_LSB = 8;
  localparam int IPA_ARB_LSB = 12;
  localparam int IPA_BMON_BIT = 16;
  localparam logic [2:0] IPA_MASK_RST = 3'h7;
  localparam logic [3:0] IPA_ARB_SIM_RST = 4'hF;
  localparam logic [3:0] IPA_ARB_MOD_RST = 4'h0;
  // =====================================================
  // status register fields
  localparam int IPA_ST_NMI_BIT = 7;
  localparam int IPA_ST_VEC_LSB = 8;
  localparam int IPA_ST_BUSY_BIT = 16;
  localparam int IPA_ST_SPUR_BIT = 17;
  // =====================================================
  // acknowledge cycle encoding
  localparam logic [2:0] IPA_FC_CPU = 3'h7;
  localparam logic [19:0] IPA_ADDR_HIGH = 20'hFFFFF;
  localparam logic [7:0] IPA_VEC_SPURIOUS = 8'h18;
  localparam logic [7:0] IPA_VEC_AUTO_BASE = 8'h18;
  localparam logic [7:0] IPA_VEC_PIT_RST = 8'h0F;
  localparam int IPA_VTAB_BYTES = 512;
  localparam int IPA_ARB_BITS = 4;
  // =====================================================
  // bus monitor timeout
  localparam int IPA_BMON_NS = 640;
  localparam int IPA_CLK_MHZ = 100;
  localparam int IPA_BMON_CYC = IPA_BMON_NS * IPA_CLK_MHZ / 1000;
  localparam logic [15:0] IPA_PIT_RST = 16'h0000;
endpackage
`default_nettype wire

/* rtl/ipa_link_if.sv */
// link between the interrupt controller and a requesting source
`default_nettype none
interface ipa_link_if;
  logic [7:1] irq_n;
  logic iack;
  logic [2:0] iack_fc;
  logic [23:0] iack_addr;
  logic iack_ext;
  logic [1:0] arb_idx;
  logic arb_en;
  logic arb_bit;
  logic arb_res;
  logic arb_res_vld;
  logic arb_done;
  logic [7:0] vec_data;
  logic vec_valid;
  logic autovec;
  modport ctrl (
    input irq_n, arb_bit, vec_data, vec_valid, autovec,
    output iack, iack_fc, iack_addr, iack_ext, arb_idx, arb_en, arb_res, arb_res_vld,
    arb_done
  );
  modport src (
    output irq_n, arb_bit, vec_data, vec_valid, autovec,
    input iack, iack_fc, iack_addr, iack_ext, arb_idx, arb_en, arb_res, arb_res_vld,
    arb_done
  );
endinterface
`default_nettype wire

/* rtl/ipa_ctrl.sv */
// interrupt recognition, acknowledge and arbitration controller
//
// The implementer's own choices: the APB register port and the address map.
`default_nettype none
// Function
// - seven request levels, seven highest
// - mask blocks levels at or below it
// - level seven ignores the mask
// - requests active low, held until acknowledge
// - level seven needs a falling edge
// - mask write under level seven re-requests
// - two consecutive falling-edge samples validate
// - pending requests taken at instruction boundary
// - highest unmasked level wins, not latched
// - acknowledge read carries level, loads mask
// - sources respond only to own level
// - serial four-bit contention, all ones highest
// - zero arbitration field gives spurious exception
// - integration field resets ones, others zero
// - always arbitrate; external only if integration wins; here when its field matches the result on bits 3:1 and result bit 0 is one
// - winner ends cycle, internal supplies vector
// - external replies vector, timeout gives spurious
// - chip-select matching only after external pass
// - internal modules use user vectors only
// - timer level field, zero disables timer
// - timer beats pins at same level
// - vector table in first 512 bytes
// - acknowledge drives function code and address ones
// - autovector request yields level autovector
module ipa_ctrl
  import ipa_pkg::*;
#(
  parameter int BMON_CYCLES = IPA_BMON_CYC
)(
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_NRST,
  // apb slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // processor core side
  input wire logic I_INSN_BOUNDARY,
  output logic O_VECTOR_VLD,
  output logic [7:0] O_VECTOR,
  output logic [8:0] O_VECTOR_ADDR,
  // link
  ipa_link_if.ctrl link
);
  initial
  begin
    if (BMON_CYCLES < 1 || BMON_CYCLES > 65535)
      $error("BMON_CYCLES out of range");
  end

  typedef enum {ST_IDLE, ST_ARB, ST_INT_WAIT, ST_EXT_WAIT} ipa_state_type;

  ipa_state_type state_reg;
  logic [7:1] samp_reg;
  logic [7:1] prev_reg;
  logic [7:1] valid_reg;
  logic nmi_reg;
  logic [2:0] mask_reg;
  logic [2:0] plvl_reg;
  logic [3:0] arb_reg;
  logic bmon_reg;
  logic [15:0] pit_per_reg;
  logic [15:0] pit_cnt_reg;
  logic pit_pend_reg;
  logic [7:0] pit_vec_reg;
  logic [2:0] lvl_reg;
  logic [1:0] bit_reg;
  logic phase_reg;
  logic in_reg;
  logic [3:0] won_reg;
  logic [15:0] tmo_reg;
  logic [7:0] last_vec_reg;
  logic spur_reg;
  logic [7:1] req_vec;
  logic [2:0] top_lvl;
  logic take;
  logic wr;
  logic rd_ok;
  logic mask_wr;
  logic ack_done;
  logic [7:0] done_vec;
  logic done_spur;
  logic pit_ack;

  // highest set request level
  function automatic logic [2:0] ipa_top(input logic [7:1] r);
    logic [2:0] t;
    t = 3'h0;
    for (int i = 1; i <= 7; i++)
      if (r[i])
        t = 3'(i);
    return t;
  endfunction

  // =====================================================
  // request sampling on falling edges
  always_ff @(negedge I_CLK_SYS or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      samp_reg <= 7'h00;
      prev_reg <= 7'h00;
    end
    else
    begin
      samp_reg <= ~link.irq_n;
      prev_reg <= samp_reg;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_NRST)
  begin
    if (!I_NRST)
      valid_reg <= 7'h00;
    else
      valid_reg <= samp_reg & prev_reg;
  end

  // =====================================================
  // request qualification
  assign wr = I_PSEL && I_PENABLE && I_PWRITE && !O_PREADY;
  assign mask_wr = wr && I_PADDR == IPA_ADDR_CTRL;
  always_comb
  begin
    req_vec = valid_reg;
    req_vec[7] = nmi_reg;
    if (plvl_reg != 3'h0 && pit_pend_reg)
      req_vec[plvl_reg] = 1'b1;
    for (int i = 1; i < 7; i++)
      if (3'(i) <= mask_reg)
        req_vec[i] = 1'b0;
  end
  assign top_lvl = ipa_top(req_vec);
  assign take = state_reg == ST_IDLE && I_INSN_BOUNDARY && top_lvl != 3'h0;
  assign pit_ack = ack_done && pit_pend_reg && plvl_reg == lvl_reg && in_reg
    && won_reg[3:1] == arb_reg[3:1];

  // level seven edge latch
  always_ff @(posedge I_CLK_SYS or negedge I_NRST)
  begin
    if (!I_NRST)
      nmi_reg <= 1'b0;
    else if ((valid_reg[7] && !(samp_reg[7] & prev_reg[7]) == 1'b0 && !valid_reg[7] == 1'b0
      && 1'b0) || (!valid_reg[7] && samp_reg[7] && prev_reg[7]))
      nmi_reg <= 1'b1;
    else if (mask_wr && valid_reg[7])
      nmi_reg <= 1'b1;
    else if (take && top_lvl == 3'h7)
      nmi_reg <= 1'b0;
  end

  // =====================================================
  // periodic tick timer
  always_ff @(posedge I_CLK_SYS or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      pit_cnt_reg <= IPA_PIT_RST;
      pit_pend_reg <= 1'b0;
    end
    else
    begin
      if (pit_per_reg == IPA_PIT_RST || pit_cnt_reg == pit_per_reg)
        pit_cnt_reg <= IPA_PIT_RST;
      else
        pit_cnt_reg <= pit_cnt_reg + 16'h0001;
      if (pit_per_reg != IPA_PIT_RST && pit_cnt_reg == pit_per_reg && plvl_reg != 3'h0)
        pit_pend_reg <= 1'b1;
      else if (pit_ack)
        pit_pend_reg <= 1'b0;
    end
  end

  // =====================================================
  // acknowledge cycle and contention
  always_ff @(posedge I_CLK_SYS or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      state_reg <= ST_IDLE;
      lvl_reg <= 3'h0;
      bit_reg <= 2'h0;
      phase_reg <= 1'b0;
      in_reg <= 1'b0;
      won_reg <= 4'h0;
      tmo_reg <= 16'h0000;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (take)
          begin
            state_reg <= ST_ARB;
            lvl_reg <= top_lvl;
            bit_reg <= 2'(IPA_ARB_BITS - 1);
            phase_reg <= 1'b0;
            won_reg <= 4'h0;
            in_reg <= (valid_reg[top_lvl] && top_lvl != 3'h0)
              || (pit_pend_reg && plvl_reg == top_lvl) || (top_lvl == 3'h7);
          end
        end
        ST_ARB:
        begin
          phase_reg <= !phase_reg;
          if (phase_reg)
          begin
            won_reg[bit_reg] <= (in_reg & arb_reg[bit_reg]) | link.arb_bit;
            if (!arb_reg[bit_reg] && link.arb_bit)
              in_reg <= 1'b0;
            bit_reg <= bit_reg - 2'h1;
            if (bit_reg == 2'h0)
            begin
              tmo_reg <= 16'h0000;
              if (((in_reg & arb_reg[0]) | link.arb_bit) == 1'b0 && won_reg[3:1] == 3'h0)
                state_reg <= ST_IDLE;
              else if (in_reg && arb_reg[3:1] == won_reg[3:1]
                && !(pit_pend_reg && plvl_reg == lvl_reg))
                state_reg <= ST_EXT_WAIT;
              else if (in_reg && arb_reg[3:1] == won_reg[3:1])
                state_reg <= ST_IDLE;
              else
                state_reg <= ST_INT_WAIT;
            end
          end
        end
        ST_INT_WAIT, ST_EXT_WAIT:
        begin
          tmo_reg <= tmo_reg + 16'h0001;
          if (link.vec_valid || link.autovec
            || (bmon_reg && tmo_reg == 16'(BMON_CYCLES - 1)))
            state_reg <= ST_IDLE;
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // completion of the acknowledge cycle and its vector
  always_comb
  begin
    ack_done = 1'b0;
    done_spur = 1'b0;
    done_vec = IPA_VEC_SPURIOUS;
    if (state_reg == ST_ARB && phase_reg && bit_reg == 2'h0)
    begin
      if (((in_reg & arb_reg[0]) | link.arb_bit) == 1'b0 && won_reg[3:1] == 3'h0)
      begin
        ack_done = 1'b1;
        done_spur = 1'b1;
      end
      else if (in_reg && arb_reg[3:1] == won_reg[3:1] && pit_pend_reg && plvl_reg == lvl_reg)
      begin
        ack_done = 1'b1;
        done_vec = pit_vec_reg;
      end
    end
    else if (state_reg == ST_INT_WAIT || state_reg == ST_EXT_WAIT)
    begin
      if (link.autovec)
      begin
        ack_done = 1'b1;
        done_vec = IPA_VEC_AUTO_BASE + {5'h00, lvl_reg};
      end
      else if (link.vec_valid)
      begin
        ack_done = 1'b1;
        done_vec = link.vec_data;
      end
      else if (bmon_reg && tmo_reg == 16'(BMON_CYCLES - 1))
      begin
        ack_done = 1'b1;
        done_spur = 1'b1;
      end
    end
  end

  // link outputs
  always_ff @(posedge I_CLK_SYS or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      link.iack <= 1'b0;
      link.iack_fc <= 3'h0;
      link.iack_addr <= 24'h000000;
      link.iack_ext <= 1'b0;
      link.arb_idx <= 2'h0;
      link.arb_en <= 1'b0;
      link.arb_res <= 1'b0;
      link.arb_res_vld <= 1'b0;
      link.arb_done <= 1'b0;
    end
    else
    begin
      if (take)
      begin
        link.iack <= 1'b1;
        link.iack_fc <= IPA_FC_CPU;
        link.iack_addr <= {IPA_ADDR_HIGH, top_lvl, 1'b1};
      end
      else if (ack_done)
        link.iack <= 1'b0;
      link.arb_en <= take || (state_reg == ST_ARB && !(phase_reg && bit_reg == 2'h0));
      link.arb_idx <= take ? 2'(IPA_ARB_BITS - 1) : (phase_reg ? bit_reg - 2'h1 : bit_reg);
      link.arb_res_vld <= state_reg == ST_ARB && phase_reg;
      link.arb_res <= (in_reg & arb_reg[bit_reg]) | link.arb_bit;
      link.arb_done <= state_reg == ST_ARB && phase_reg && bit_reg == 2'h0;
      if (state_reg == ST_ARB && phase_reg && bit_reg == 2'h0 && in_reg
        && arb_reg[3:1] == won_reg[3:1] && !(pit_pend_reg && plvl_reg == lvl_reg)
        && ((in_reg & arb_reg[0]) | link.arb_bit))
        link.iack_ext <= 1'b1;
      else if (ack_done)
        link.iack_ext <= 1'b0;
    end
  end

  // core outputs
  always_ff @(posedge I_CLK_SYS or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      O_VECTOR_VLD <= 1'b0;
      O_VECTOR <= 8'h00;
      O_VECTOR_ADDR <= 9'h000;
      last_vec_reg <= 8'h00;
      spur_reg <= 1'b0;
    end
    else
    begin
      O_VECTOR_VLD <= ack_done;
      if (ack_done)
      begin
        O_VECTOR <= done_vec;
        O_VECTOR_ADDR <= 9'((IPA_VTAB_BYTES - 1) & {done_vec, 1'b0});
        last_vec_reg <= done_vec;
        spur_reg <= done_spur;
      end
    end
  end

  // =====================================================
  // apb registers
  assign rd_ok = I_PADDR == IPA_ADDR_CTRL || I_PADDR == IPA_ADDR_PIT
    || I_PADDR == IPA_ADDR_VEC || I_PADDR == IPA_ADDR_STAT;
  always_ff @(posedge I_CLK_SYS or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      mask_reg <= IPA_MASK_RST;
      plvl_reg <= 3'h0;
      arb_reg <= IPA_ARB_SIM_RST;
      bmon_reg <= 1'b1;
      pit_per_reg <= IPA_PIT_RST;
      pit_vec_reg <= IPA_VEC_PIT_RST;
    end
    else
    begin
      if (take)
        mask_reg <= top_lvl;
      else if (mask_wr)
        mask_reg <= I_PWDATA[IPA_MASK_LSB +: 3];
      if (mask_wr)
      begin
        plvl_reg <= I_PWDATA[IPA_PLVL_LSB +: 3];
        arb_reg <= I_PWDATA[IPA_ARB_LSB +: 4];
        bmon_reg <= I_PWDATA[IPA_BMON_BIT];
      end
      if (wr && I_PADDR == IPA_ADDR_PIT)
        pit_per_reg <= I_PWDATA[15:0];
      if (wr && I_PADDR == IPA_ADDR_VEC)
        pit_vec_reg <= I_PWDATA[7:0];
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      O_PREADY <= 1'b0;
      O_PSLVERR <= 1'b0;
      O_PRDATA <= 32'h00000000;
    end
    else
    begin
      O_PREADY <= I_PSEL && I_PENABLE && !O_PREADY;
      O_PSLVERR <= I_PSEL && I_PENABLE && !O_PREADY && !rd_ok;
      O_PRDATA <= 32'h00000000;
      if (I_PSEL && I_PENABLE && !O_PREADY && !I_PWRITE)
      begin
        case (I_PADDR)
          IPA_ADDR_CTRL:
            O_PRDATA <= 32'({bmon_reg, arb_reg, 1'b0, plvl_reg, mask_reg, 5'h00});
          IPA_ADDR_PIT:
            O_PRDATA <= {16'h0000, pit_per_reg};
          IPA_ADDR_VEC:
            O_PRDATA <= {24'h000000, pit_vec_reg};
          IPA_ADDR_STAT:
            O_PRDATA <= 32'({spur_reg, state_reg != ST_IDLE, last_vec_reg, nmi_reg,
              valid_reg});
          default:
            O_PRDATA <= 32'h00000000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* rtl/ipa_source.sv */
// requesting source: internal module or external device at one level
`default_nettype none
module ipa_source
  import ipa_pkg::*;
(
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_NRST,
  // user side
  input wire logic I_REQ,
  input wire logic I_EXTERNAL,
  input wire logic [2:0] I_LEVEL,
  input wire logic [3:0] I_ARB,
  input wire logic [7:0] I_VECTOR,
  input wire logic I_AUTOVEC,
  input wire logic I_RESPOND,
  output logic O_PENDING,
  output logic O_ACKED,
  // link
  ipa_link_if.src link
);
  logic hit_reg;
  logic lost_reg;
  logic hit;
  logic contend;
  logic lose_now;
  logic reply;
  logic ack_seen;

  // the level on the address bus must match our own
  assign hit = link.iack && O_PENDING && link.iack_addr[3:1] == I_LEVEL;
  // internal modules with a non-zero field contend until they lose a bit
  assign contend = hit && !I_EXTERNAL && I_ARB != IPA_ARB_MOD_RST && !lost_reg;
  assign lose_now = link.arb_res_vld && link.arb_res && !link.arb_bit;
  // an acknowledge for our level has ended, whoever finished it
  assign ack_seen = hit_reg && !link.iack;
  assign reply = hit && I_RESPOND && !link.vec_valid && !link.autovec
    && ((I_EXTERNAL && link.iack_ext) || (contend && !lose_now && link.arb_done));

  always_ff @(posedge I_CLK_SYS or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      O_PENDING <= 1'b0;
      O_ACKED <= 1'b0;
      hit_reg <= 1'b0;
      lost_reg <= 1'b0;
      link.irq_n <= 7'h7F;
      link.arb_bit <= 1'b0;
      link.vec_data <= 8'h00;
      link.vec_valid <= 1'b0;
      link.autovec <= 1'b0;
    end
    else
    begin
      O_ACKED <= reply;
      if (reply || ack_seen)
        O_PENDING <= 1'b0;
      else if (I_REQ && I_LEVEL != 3'h0)
        O_PENDING <= 1'b1;
      link.irq_n <= 7'h7F;
      if (O_PENDING && !reply && !ack_seen && I_LEVEL != 3'h0)
        link.irq_n[I_LEVEL] <= 1'b0;
      if (!link.iack)
      begin
        hit_reg <= 1'b0;
        lost_reg <= 1'b0;
      end
      else
      begin
        if (hit)
          hit_reg <= 1'b1;
        if (contend && lose_now)
          lost_reg <= 1'b1;
      end
      link.arb_bit <= link.arb_en && contend && !lose_now && I_ARB[link.arb_idx];
      link.vec_valid <= reply && !(I_AUTOVEC && I_EXTERNAL);
      link.autovec <= reply && I_AUTOVEC && I_EXTERNAL;
      link.vec_data <= reply ? I_VECTOR : 8'h00;
    end
  end
endmodule
`default_nettype wire

/* tb/ipa_checker.sv */
// concurrent checks on the acknowledge link between controller and source
`default_nettype none
module ipa_checker
  import ipa_pkg::*;
(
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_NRST,
  // acknowledge cycle
  input wire logic iack,
  input wire logic [2:0] iack_fc,
  input wire logic [23:0] iack_addr,
  input wire logic iack_ext,
  // contention
  input wire logic [1:0] arb_idx,
  input wire logic arb_en,
  input wire logic arb_done,
  // reply
  input wire logic vec_valid,
  input wire logic autovec
);
  localparam int ACK_MAX = 60;
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_NRST);
  // ==========================================
  // sequences
  sequence s_take;
    $rose(iack);
  endsequence
  sequence s_contend;
    iack [*8];
  endsequence
  // ==========================================
  // properties
  property p_fc;
    iack |-> iack_fc == IPA_FC_CPU;
  endproperty
  property p_addr;
    iack |-> iack_addr[23:4] == IPA_ADDR_HIGH && iack_addr[0] && iack_addr[3:1] != 3'h0;
  endproperty
  property p_lvl_hold;
    iack && $past(iack) |-> $stable(iack_addr);
  endproperty
  property p_arb_start;
    s_take |-> ##[0:2] (arb_en && arb_idx == 2'h3);
  endproperty
  property p_ack_min;
    s_take |-> s_contend;
  endproperty
  property p_done;
    s_take |-> ##[7:12] arb_done;
  endproperty
  property p_ext;
    $rose(iack_ext) |-> iack && (arb_done || $past(arb_done));
  endproperty
  property p_vec;
    vec_valid |-> iack;
  endproperty
  property p_autovector_request;
    autovec |-> iack && iack_ext;
  endproperty
  property p_end;
    s_take |-> ##[8:ACK_MAX] !iack;
  endproperty
  a_fc: assert property (p_fc) else $error("ack function code wrong");
  a_addr: assert property (p_addr) else $error("ack address wrong");
  a_lvl_hold: assert property (p_lvl_hold) else $error("ack level moved");
  a_arb_start: assert property (p_arb_start) else $error("no msb first");
  a_ack_min: assert property (p_ack_min) else $error("ack too short");
  a_done: assert property (p_done) else $error("contention late");
  a_ext: assert property (p_ext) else $error("external pass early");
  a_vec: assert property (p_vec) else $error("vector outside ack");
  a_autovector_request: assert property (p_autovector_request) else $error("internal autovector");
  a_end: assert property (p_end) else $error("ack never ends");
endmodule
`default_nettype wire

/* tb/ipa_tb.sv */
// self-checking bench joining the controller and one requesting source
`default_nettype none
module ipa_tb
  import ipa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, nrst, psel, penable, pwrite, pready, pslverr, boundary, vec_vld;
  logic req, ext, autovector_request, respond, pending, acked;
  logic [2:0] lvl;
  logic [3:0] arb;
  logic [7:0] paddr, vec, s_vec;
  logic [8:0] vec_addr;
  logic [31:0] pwdata, prdata;
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  ipa_link_if link_if ();
  ipa_ctrl #(.BMON_CYCLES(8)) ipa_ctrl_inst (.I_CLK_SYS(clk_sys), .I_NRST(nrst),
    .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_INSN_BOUNDARY(boundary), .O_VECTOR_VLD(vec_vld), .O_VECTOR(vec),
    .O_VECTOR_ADDR(vec_addr), .link(link_if));
  ipa_source ipa_source_inst (.I_CLK_SYS(clk_sys), .I_NRST(nrst), .I_REQ(req),
    .I_EXTERNAL(ext), .I_LEVEL(lvl), .I_ARB(arb), .I_VECTOR(s_vec), .I_AUTOVEC(autovector_request),
    .I_RESPOND(respond), .O_PENDING(pending), .O_ACKED(acked), .link(link_if));
  ipa_checker ipa_checker_inst (.I_CLK_SYS(clk_sys), .I_NRST(nrst), .iack(link_if.iack),
    .iack_fc(link_if.iack_fc), .iack_addr(link_if.iack_addr),
    .iack_ext(link_if.iack_ext), .arb_idx(link_if.arb_idx), .arb_en(link_if.arb_en),
    .arb_done(link_if.arb_done), .vec_valid(link_if.vec_valid),
    .autovec(link_if.autovec));
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // ==========================================
  // shared tasks
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // apb master: hold the request until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++)
      @(posedge clk_sys);
    check({31'h0, pready}, 32'h1, "apb answer");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  function automatic logic [31:0] cw(input logic [2:0] m, input logic [2:0] pl);
    cw = 32'h0;
    cw[IPA_BMON_BIT] = 1'b1;
    cw[IPA_ARB_LSB +: 4] = IPA_ARB_SIM_RST;
    cw[IPA_PLVL_LSB +: 3] = pl;
    cw[IPA_MASK_LSB +: 3] = m;
  endfunction
  task automatic raise(input logic x, input logic [2:0] l, input logic [3:0] ar,
    input logic [7:0] v, input logic av, input logic rs);
    @(posedge clk_sys);
    ext <= x;
    lvl <= l;
    arb <= ar;
    s_vec <= v;
    autovector_request <= av;
    respond <= rs;
    req <= 1'b1;
    @(posedge clk_sys);
    req <= 1'b0;
  endtask
  task automatic wait_vec(input logic [7:0] exp);
    int n;
    for (n = 0; n < 300 && vec_vld !== 1'b1; n++)
      @(negedge clk_sys);
    check({31'h0, vec_vld}, 32'h1, "vector valid");
    check({24'h0, vec}, {24'h0, exp}, "vector");
    check({23'h0, vec_addr}, {23'h0, exp, 1'b0}, "vector address");
  endtask
  task automatic expect_none(input int n);
    int k;
    k = 0;
    repeat (n)
    begin
      @(negedge clk_sys);
      if (vec_vld === 1'b1)
        k++;
    end
    check(k, 0, "unexpected vector");
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    apb(1'b0, IPA_ADDR_CTRL, 32'h0, r, e);
    check(r, cw(3'h7, 3'h0), "ctrl reset");
    apb(1'b0, 8'h10, 32'h0, r, e);
    check({31'h0, e}, 32'h1, "unmapped error");
    check(r, 32'h0, "unmapped read");
    check({25'h0, link_if.irq_n}, 32'h7F, "lines idle");
    $display("test reset done");
  endtask
  task automatic t_mask();
    logic [31:0] r;
    logic e;
    logic [31:0] lo;
    // integration field lowered to one so the internal source can win
    lo = 32'h0000E000;
    wr(IPA_ADDR_CTRL, cw(3'h3, 3'h0) & ~lo);
    boundary <= 1'b1;
    raise(1'b0, 3'h3, 4'h5, 8'h40, 1'b0, 1'b1);
    expect_none(40);
    @(posedge clk_sys);
    boundary <= 1'b0;
    wr(IPA_ADDR_CTRL, cw(3'h2, 3'h0) & ~lo);
    expect_none(20);
    @(posedge clk_sys);
    boundary <= 1'b1;
    wait_vec(8'h40);
    apb(1'b0, IPA_ADDR_CTRL, 32'h0, r, e);
    check(r, cw(3'h3, 3'h0) & ~lo, "mask loaded");
    repeat (4) @(negedge clk_sys);
    check({31'h0, pending}, 32'h0, "source released");
    $display("test mask done");
  endtask
  task automatic t_spur_ext();
    logic [31:0] r;
    logic e;
    wr(IPA_ADDR_CTRL, cw(3'h0, 3'h0) & ~32'h0000F000);
    raise(1'b0, 3'h4, 4'h0, 8'h21, 1'b0, 1'b1);
    wait_vec(IPA_VEC_SPURIOUS);
    apb(1'b0, IPA_ADDR_STAT, 32'h0, r, e);
    check({31'h0, r[IPA_ST_SPUR_BIT]}, 32'h1, "spurious flag");
    wr(IPA_ADDR_CTRL, cw(3'h0, 3'h0));
    raise(1'b1, 3'h5, 4'h0, 8'h55, 1'b0, 1'b1);
    wait_vec(8'h55);
    wr(IPA_ADDR_CTRL, cw(3'h0, 3'h0));
    raise(1'b1, 3'h6, 4'h0, 8'h66, 1'b1, 1'b1);
    wait_vec(IPA_VEC_AUTO_BASE + 8'h06);
    $display("test spurious and external done");
  endtask
  task automatic t_top();
    wr(IPA_ADDR_CTRL, cw(3'h7, 3'h0) & ~32'h0000E000);
    raise(1'b0, 3'h7, 4'h9, 8'h47, 1'b0, 1'b1);
    wait_vec(8'h47);
    expect_none(30);
    $display("test top level done");
  endtask
  task automatic t_timer();
    wr(IPA_ADDR_VEC, 32'h77);
    wr(IPA_ADDR_PIT, 32'h14);
    wr(IPA_ADDR_CTRL, cw(3'h0, 3'h0));
    expect_none(60);
    wr(IPA_ADDR_CTRL, cw(3'h2, 3'h2));
    raise(1'b1, 3'h2, 4'h0, 8'h52, 1'b0, 1'b1);
    repeat (30) @(posedge clk_sys);
    wr(IPA_ADDR_CTRL, cw(3'h0, 3'h2));
    wait_vec(8'h77);
    $display("test timer done");
  endtask
  task automatic t_timeout();
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset();
    wr(IPA_ADDR_CTRL, cw(3'h0, 3'h0));
    raise(1'b1, 3'h4, 4'h0, 8'h44, 1'b0, 1'b0);
    wait_vec(IPA_VEC_SPURIOUS);
    $display("test timeout done");
  endtask
  initial
  begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    boundary = 1'b0;
    req = 1'b0;
    ext = 1'b0;
    lvl = 3'h0;
    arb = 4'h0;
    s_vec = 8'h00;
    autovector_request = 1'b0;
    respond = 1'b1;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset();
    t_mask();
    t_spur_ext();
    t_top();
    t_timer();
    t_timeout();
    print_verdict();
  end
endmodule
`default_nettype wire
